/* core/spc_pin_if.sv */
// DRAM pin command, power, termination and strobed data interface
// Contract
// - Rank select high masks the command
// - Four select and strobe pins form command
// - Clock gate high keeps buffers enabled
// - Gate low: idle banks precharge-down, else active-down
// - Gate rise exits self-refresh without clock
// - Power-down keeps only clock, termination, gate
// - Self-refresh keeps only the gate input
// - Activate takes row, read/write take column
// - Address bit ten is auto-precharge on accesses
// - Precharge bit ten picks one or all
// - Address bit twelve low chops the burst
// - Mode set carries opcode on address
// - Bank select picks the addressed bank
// - Bank select picks the mode register
// - Registered termination enable terminates data pins
// - Termination ignored when mode register disables it
// - Strobes edge-aligned on reads, centred on writes
// - Lower strobe times low byte, upper high
// - Strobes are differential pairs only
// - Masked write bytes are never stored
// - Each mask sampled on both strobe edges
// - Command, address and termination inputs sampled at clock rising crossing
// - Reset is active low and asynchronous
`timescale 1ns/100ps
module spc_pin_if #(
   parameter logic [14:0] TERM_FIELD_MASK = 15'h0244,
   parameter int WR_DEPTH = spc_pkg::WR_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Link clock and command pins
   input wire logic ck_t,
   input wire logic ck_c,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] bank_select,
   input wire logic [14:0] addr,
   input wire logic termination_enable,
   // Data pins, lane 0 lower byte, lane 1 upper byte
   input wire logic [15:0] dq_rx,
   output logic [15:0] dq_tx,
   output logic dq_oe,
   input wire logic lower_byte_strobe_t_rx,
   input wire logic lower_byte_strobe_c_rx,
   input wire logic upper_byte_strobe_t_rx,
   input wire logic upper_byte_strobe_c_rx,
   output logic lower_byte_strobe_t_tx,
   output logic lower_byte_strobe_c_tx,
   output logic upper_byte_strobe_t_tx,
   output logic upper_byte_strobe_c_tx,
   output logic strobe_oe,
   input wire logic lower_byte_mask,
   input wire logic upper_byte_mask,
   // Decoded command
   output logic cmd_valid,
   output logic [3:0] cmd_code,
   output logic [2:0] cmd_bank,
   output logic [14:0] row_addr,
   output logic [9:0] col_addr,
   output logic auto_precharge,
   output logic burst_chop,
   output logic precharge_all,
   output logic [14:0] mode_opcode,
   // Status
   output spc_pkg::spc_pwr_e power_state,
   output logic [7:0] bank_open,
   output logic term_on,
   output logic cmd_buf_en,
   output logic ck_buf_en,
   output logic term_buf_en,
   output logic [14:0] mode_register_one,
   output logic wr_overflow,
   // Write stream out
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [15:0] wr_data,
   output logic [1:0] wr_byte_en,
   output logic wr_fifo_ready,
   // Read stream in
   input wire logic rd_valid,
   output logic rd_ready,
   input wire logic [15:0] rd_data,
   input wire logic rd_last
);
   logic [spc_pkg::CA_PINS-1:0] ca_meta_ff;
   logic [spc_pkg::CA_PINS-1:0] ca_sync_ff;
   logic [spc_pkg::DATA_PINS-1:0] dat_meta_ff;
   logic [spc_pkg::DATA_PINS-1:0] dat_sync_ff;
   logic s_ck_t, s_ck_c, s_cke, s_term;
   logic [3:0] s_cmd;
   logic [2:0] s_bank;
   logic [14:0] s_addr;
   logic [15:0] s_dq;
   logic [1:0] s_dqs_t, s_dqs_c, s_dm;
   logic ck_t_d_ff;
   logic cke_d_ff;
   logic [1:0] dqs_t_d_ff;
   logic ck_rise;
   logic cmd_take;
   logic [1:0] lane_edge;
   logic [1:0] lane_keep;
   logic wr_push;
   logic wr_space;
   logic wr_window_ff;
   logic rd_acc;
   logic rd_done_ff;
   logic strobe_ff;
   spc_pkg::spc_pwr_e pwr_ff;
   spc_pkg::spc_pwr_e nxt_pwr;
   logic [14:0] mode_reg_ff [spc_pkg::NUM_MODE_REGS];
   logic [7:0] bank_open_ff;
   logic term_on_ff;
   logic mr1_term_en;
   logic cmd_valid_ff, auto_pre_ff, chop_ff, pre_all_ff, overflow_ff;
   logic [3:0] cmd_code_ff;
   logic [2:0] cmd_bank_ff;
   logic [14:0] row_ff;
   logic [9:0] col_ff;
   logic [15:0] dq_tx_ff;
   logic dq_oe_ff;

   // Two-stage synchronisers; the link clock is sampled like any pin
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ca_meta_ff <= '0;
         ca_sync_ff <= '0;
         dat_meta_ff <= '0;
         dat_sync_ff <= '0;
      end else begin
         ca_meta_ff <= {ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
                        termination_enable};
         ca_sync_ff <= ca_meta_ff;
         dat_meta_ff <= {dq_rx, upper_byte_strobe_t_rx, lower_byte_strobe_t_rx,
                         upper_byte_strobe_c_rx, lower_byte_strobe_c_rx,
                         upper_byte_mask, lower_byte_mask};
         dat_sync_ff <= dat_meta_ff;
      end
   end

   // Unpack synchronised pins
   assign {s_ck_t, s_ck_c, s_cke, s_cmd, s_bank, s_addr, s_term} = ca_sync_ff;
   assign {s_dq, s_dqs_t, s_dqs_c, s_dm} = dat_sync_ff;

   // Edge history, read only from the second stage
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ck_t_d_ff <= 1'b0;
         cke_d_ff <= 1'b0;
         dqs_t_d_ff <= 2'h0;
      end else begin
         ck_t_d_ff <= s_ck_t;
         cke_d_ff <= s_cke;
         dqs_t_d_ff <= s_dqs_t;
      end
   end

   // Clock crossing: true rises while complement is low; dead in self-refresh
   assign ck_rise = s_ck_t & ~ck_t_d_ff & ~s_ck_c & (pwr_ff != spc_pkg::SPC_SELF_REF);
   // Commands only while awake, selected and with the gate high
   assign cmd_take = ck_rise & (pwr_ff == spc_pkg::SPC_ACTIVE) & s_cke & ~s_cmd[3];

   // Power state selection
   always_comb begin
      nxt_pwr = pwr_ff;
      unique case (pwr_ff)
         spc_pkg::SPC_ACTIVE: begin
            if (ck_rise && !s_cke) begin
               if (s_cmd == spc_pkg::CMD_REFRESH && bank_open_ff == '0) begin
                  nxt_pwr = spc_pkg::SPC_SELF_REF;
               end else if (bank_open_ff != '0) begin
                  nxt_pwr = spc_pkg::SPC_ACT_PDOWN;
               end else begin
                  nxt_pwr = spc_pkg::SPC_PRE_PDOWN;
               end
            end
         end
         spc_pkg::SPC_PRE_PDOWN, spc_pkg::SPC_ACT_PDOWN: begin
            if (ck_rise && s_cke) begin
               nxt_pwr = spc_pkg::SPC_ACTIVE;
            end
         end
         spc_pkg::SPC_SELF_REF: begin
            if (s_cke && !cke_d_ff) begin
               nxt_pwr = spc_pkg::SPC_ACTIVE;
            end
         end
      endcase
   end

   // Power state register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pwr_ff <= spc_pkg::SPC_ACTIVE;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end

   // Buffer enables follow the power state
   assign cmd_buf_en = (pwr_ff == spc_pkg::SPC_ACTIVE);
   assign ck_buf_en = (pwr_ff != spc_pkg::SPC_SELF_REF);
   assign term_buf_en = (pwr_ff != spc_pkg::SPC_SELF_REF);

   // Decoded command capture
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_valid_ff <= 1'b0;
         cmd_code_ff <= spc_pkg::CMD_NOP;
         cmd_bank_ff <= '0;
         row_ff <= '0;
         col_ff <= '0;
         auto_pre_ff <= 1'b0;
         chop_ff <= 1'b0;
         pre_all_ff <= 1'b0;
      end else begin
         cmd_valid_ff <= cmd_take;
         if (cmd_take) begin
            cmd_code_ff <= s_cmd;
            cmd_bank_ff <= s_bank;
            row_ff <= s_addr;
            col_ff <= s_addr[spc_pkg::COL_W-1:0];
            auto_pre_ff <= s_addr[spc_pkg::PRECHARGE_SCOPE_POS];
            chop_ff <= ~s_addr[spc_pkg::CHOP_SELECT_POS];
            pre_all_ff <= s_addr[spc_pkg::PRECHARGE_SCOPE_POS];
         end
      end
   end

   // Open-row tracking; auto-precharge closes the bank at the access
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bank_open_ff <= spc_pkg::BANK_OPEN_RST;
      end else if (cmd_take) begin
         unique case (s_cmd)
            spc_pkg::CMD_ACTIVATE: bank_open_ff[s_bank] <= 1'b1;
            spc_pkg::CMD_PRECHARGE: begin
               if (s_addr[spc_pkg::PRECHARGE_SCOPE_POS]) begin
                  bank_open_ff <= '0;
               end else begin
                  bank_open_ff[s_bank] <= 1'b0;
               end
            end
            spc_pkg::CMD_READ, spc_pkg::CMD_WRITE: begin
               if (s_addr[spc_pkg::PRECHARGE_SCOPE_POS]) begin
                  bank_open_ff[s_bank] <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // Mode registers; an upper bank select bit set is a reserved target
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < spc_pkg::NUM_MODE_REGS; i++) begin
            mode_reg_ff[i] <= spc_pkg::MODE_REG_RST;
         end
      end else if (cmd_take && s_cmd == spc_pkg::CMD_MODE_SET && !s_bank[2]) begin
         mode_reg_ff[s_bank[1:0]] <= s_addr;
      end
   end

   assign mode_register_one = mode_reg_ff[spc_pkg::MODE_REGISTER_ONE];
   assign mr1_term_en = |(mode_register_one & TERM_FIELD_MASK);

   // Termination, registered at the clock crossing
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         term_on_ff <= 1'b0;
      end else if (!mr1_term_en || pwr_ff == spc_pkg::SPC_SELF_REF) begin
         term_on_ff <= 1'b0;
      end else if (ck_rise) begin
         term_on_ff <= s_term;
      end
   end

   // Write window opens at a write command, closes at any other access
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_window_ff <= 1'b0;
      end else if (pwr_ff != spc_pkg::SPC_ACTIVE) begin
         wr_window_ff <= 1'b0;
      end else if (cmd_take && s_cmd != spc_pkg::CMD_NOP) begin
         wr_window_ff <= (s_cmd == spc_pkg::CMD_WRITE);
      end
   end

   // Per-lane strobe edges; a pair not in opposition is not an edge
   for (genvar g = 0; g < 2; g++) begin : g_lane
      assign lane_edge[g] = (s_dqs_t[g] != dqs_t_d_ff[g]) & (s_dqs_t[g] != s_dqs_c[g]);
      assign lane_keep[g] = lane_edge[g] & ~s_dm[g];
   end

   // Both lanes share one word so simultaneous edges lose nothing
   assign wr_push = wr_window_ff & (|lane_keep);

   // Overflow is sticky: the controller cannot be stalled
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         overflow_ff <= 1'b0;
      end else if (wr_push && !wr_space) begin
         overflow_ff <= 1'b1;
      end
   end

   spc_fifo #(
      .WIDTH(spc_pkg::WR_WORD_W),
      .DEPTH(WR_DEPTH)
   ) u_wr_fifo (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_valid(wr_push),
      .in_ready(wr_space),
      .in_data({lane_keep, s_dq}),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data({wr_byte_en, wr_data})
   );

   // Reads accepted only while awake
   assign rd_ready = (pwr_ff == spc_pkg::SPC_ACTIVE) & s_cke;
   assign rd_acc = rd_valid & rd_ready;

   // Read drive: data and strobe change together, edge aligned
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dq_tx_ff <= '0;
         dq_oe_ff <= 1'b0;
         strobe_ff <= 1'b0;
         rd_done_ff <= 1'b0;
      end else begin
         rd_done_ff <= rd_acc & rd_last;
         if (rd_acc) begin
            dq_tx_ff <= rd_data;
            dq_oe_ff <= 1'b1;
            strobe_ff <= ~strobe_ff;
         end else if (rd_done_ff) begin
            dq_oe_ff <= 1'b0;
         end
      end
   end

   // Outputs
   assign dq_tx = dq_tx_ff;
   assign dq_oe = dq_oe_ff;
   assign strobe_oe = dq_oe_ff;
   assign lower_byte_strobe_t_tx = strobe_ff;
   assign lower_byte_strobe_c_tx = ~strobe_ff;
   assign upper_byte_strobe_t_tx = strobe_ff;
   assign upper_byte_strobe_c_tx = ~strobe_ff;
   assign cmd_valid = cmd_valid_ff;
   assign cmd_code = cmd_code_ff;
   assign cmd_bank = cmd_bank_ff;
   assign row_addr = row_ff;
   assign col_addr = col_ff;
   assign auto_precharge = auto_pre_ff;
   assign burst_chop = chop_ff;
   assign precharge_all = pre_all_ff;
   assign mode_opcode = row_ff;
   assign power_state = pwr_ff;
   assign bank_open = bank_open_ff;
   assign term_on = term_on_ff;
   assign wr_overflow = overflow_ff;
   assign wr_fifo_ready = wr_space;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence seq_last_beat;
      rd_valid && rd_ready && rd_last;
   endsequence
   sequence seq_idle_beat;
      !(rd_valid && rd_ready);
   endsequence

   AST_CS_MASK: assert property (ck_rise && s_cmd[3] |=> !cmd_valid)
      else $error("command taken with rank deselected");
   AST_CMD_CODE: assert property (cmd_take |=> cmd_valid && cmd_code == $past(s_cmd))
      else $error("command code mismatch");
   AST_PD_KIND: assert property (pwr_ff == spc_pkg::SPC_ACTIVE && ck_rise && !s_cke
      && bank_open_ff != '0 |=> pwr_ff == spc_pkg::SPC_ACT_PDOWN)
      else $error("open row did not give active power-down");
   AST_SR_EXIT: assert property (pwr_ff == spc_pkg::SPC_SELF_REF && s_cke && !cke_d_ff
      |=> pwr_ff == spc_pkg::SPC_ACTIVE)
      else $error("gate rise did not exit self-refresh");
   AST_SR_TERM: assert property (pwr_ff == spc_pkg::SPC_SELF_REF |=> !term_on_ff)
      else $error("termination active in self-refresh");
   AST_AUTO_PRE: assert property (cmd_take && s_cmd == spc_pkg::CMD_READ
      |=> auto_precharge == $past(s_addr[10]))
      else $error("auto-precharge bit wrong");
   AST_PRE_ALL: assert property (cmd_take && s_cmd == spc_pkg::CMD_PRECHARGE && s_addr[10]
      |=> bank_open_ff == '0)
      else $error("precharge all left a bank open");
   AST_TERM_OFF: assert property (!mr1_term_en |=> !term_on_ff)
      else $error("termination on while disabled");
   AST_MASKED: assert property (wr_valid |-> wr_byte_en != 2'h0)
      else $error("fully masked word reached the write stream");
   AST_RD_RELEASE: assert property (seq_last_beat ##1 seq_idle_beat |=> !dq_oe)
      else $error("data pins still driven after burst");
endmodule // spc_pin_if

/* core/spc_pkg.sv */
// Shared constants and types for the DRAM pin command interface
package spc_pkg;

   // Command codes as {rank select, row strobe, column strobe, write enable}
   localparam logic [3:0] CMD_MODE_SET = 4'h0;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_ACTIVATE = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_CALIBRATE = 4'h6;
   localparam logic [3:0] CMD_NOP = 4'h7;

   // Address field widths and special bit positions
   localparam int ROW_W = 15;
   localparam int COL_W = 10;
   localparam int BANK_W = 3;
   localparam int NUM_BANKS = 8;
   localparam int NUM_MODE_REGS = 4;
   localparam int PRECHARGE_SCOPE_POS = 10;
   localparam int CHOP_SELECT_POS = 12;
   localparam logic [1:0] MODE_REGISTER_ONE = 2'h1;

   // Pin synchroniser depth and write path word layout
   localparam int SYNC_STAGES = 2;
   localparam int CA_PINS = 26;
   localparam int DATA_PINS = 22;
   localparam int WR_WORD_W = 18;
   localparam int WR_FIFO_DEPTH = 8;

   // Reset values
   localparam logic [ROW_W-1:0] MODE_REG_RST = 15'h0000;
   localparam logic [NUM_BANKS-1:0] BANK_OPEN_RST = 8'h00;

   // Power states of the device
   typedef enum logic [1:0] {
      SPC_ACTIVE,
      SPC_PRE_PDOWN,
      SPC_ACT_PDOWN,
      SPC_SELF_REF
   } spc_pwr_e;

endpackage

/* core/spc_fifo.sv */
// Write data FIFO with valid/ready on both sides
`timescale 1ns/100ps
module spc_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   // Honest flags: full refuses, empty shows nothing
   assign in_ready = (count_ff != FULL);
   assign out_valid = (count_ff != '0);
   assign out_data = mem[rd_ptr_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Storage, no reset needed on the data array
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   // Pointers wrap explicitly so any depth works
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
         end
      end
   end

   // Occupancy
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count_ff <= '0;
      end else if (push && !pop) begin
         count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
         count_ff <= count_ff - 1'b1;
      end
   end
endmodule // spc_fifo

/* tb/spc_ctl_model.sv */
// Memory controller model driving command, clock gate and write pins
`timescale 1ns/100ps
module spc_ctl_model (
   // Clock
   input wire logic ref_clk,
   // Link clock and command pins
   output logic ck_t,
   output logic ck_c,
   output logic cke,
   output logic [3:0] cmd,
   output logic [2:0] bank_select,
   output logic [14:0] addr,
   output logic termination_enable,
   // Write pins, bit 0 lower lane
   output logic [15:0] dq,
   output logic [1:0] strobe,
   output logic [1:0] byte_mask
);
   // Link clock stands still between commands
   initial begin
      ck_t = 1'b0;
      ck_c = 1'b1;
      cke = 1'b1;
      cmd = spc_pkg::CMD_NOP;
      bank_select = 3'h0;
      addr = 15'h0000;
      termination_enable = 1'b0;
      dq = 16'h0000;
      strobe = 2'h0;
      byte_mask = 2'h0;
   end
   // Whole code set with the rise, gate high for accesses
   task automatic rise(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
      input logic g);
      @(posedge ref_clk);
      cmd <= c;
      bank_select <= b;
      addr <= a;
      cke <= g;
      ck_t <= 1'b1;
      ck_c <= 1'b0;
   endtask
   // Fall; address hold is over, so it no longer shows the old value; caller times the low phase
   task automatic fall();
      @(posedge ref_clk);
      ck_t <= 1'b0;
      ck_c <= 1'b1;
      addr <= ~addr;
   endtask
   // Gate change without any clock
   task automatic gate(input logic g);
      @(posedge ref_clk);
      cke <= g;
   endtask
   task automatic term(input logic v);
      @(posedge ref_clk);
      termination_enable <= v;
   endtask
   // Data settles a cycle before the edge, so edges sit mid-eye
   task automatic beat(input logic [15:0] d, input logic [1:0] m);
      @(posedge ref_clk);
      dq <= d;
      byte_mask <= m;
      @(posedge ref_clk);
      strobe <= ~strobe;
      repeat (2) @(posedge ref_clk);
      dq <= ~d;
      byte_mask <= ~m;
   endtask
endmodule // spc_ctl_model

/* tb/tb_top.sv */
// Self-checking bench for the DRAM pin command interface
`timescale 1ns/100ps
module tb_top;
   logic ref_clk, nrst, wr_ready, rd_valid, rd_last, ck_t, ck_c, cke, termination_enable;
   logic dq_oe, strobe_oe, cmd_valid, auto_precharge, burst_chop, precharge_all, term_on;
   logic cmd_buf_en, ck_buf_en, term_buf_en, wr_overflow, wr_valid, wr_fifo_ready, rd_ready;
   logic [15:0] rd_data, dq_tx, wr_data, dq_drv, dq_bus;
   logic [3:0] cmd, cmd_code;
   logic [2:0] bank_select, cmd_bank;
   logic [14:0] addr, row_addr, mode_opcode, mode_register_one;
   logic [1:0] strobe, strobe_bus, byte_mask, wr_byte_en, st_t, st_c, prev;
   logic [9:0] col_addr;
   logic [7:0] bank_open;
   spc_pkg::spc_pwr_e power_state;
   int mismatches, checks;
   // Wire level from whichever side has its enable up
   assign dq_bus = dq_oe ? dq_tx : dq_drv;
   assign strobe_bus = strobe_oe ? st_t : strobe;
   spc_ctl_model u_ctl (.ref_clk(ref_clk), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cmd(cmd),
      .bank_select(bank_select), .addr(addr), .termination_enable(termination_enable),
      .dq(dq_drv), .strobe(strobe), .byte_mask(byte_mask));
   // Complements always opposite the true strobes
   spc_pin_if u_dut (.ref_clk(ref_clk), .nrst(nrst), .ck_t(ck_t), .ck_c(ck_c), .cke(cke),
      .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .bank_select(bank_select),
      .addr(addr), .termination_enable(termination_enable), .dq_rx(dq_bus), .dq_tx(dq_tx),
      .dq_oe(dq_oe), .lower_byte_strobe_t_rx(strobe_bus[0]),
      .lower_byte_strobe_c_rx(~strobe_bus[0]), .upper_byte_strobe_t_rx(strobe_bus[1]),
      .upper_byte_strobe_c_rx(~strobe_bus[1]), .lower_byte_strobe_t_tx(st_t[0]),
      .lower_byte_strobe_c_tx(st_c[0]), .upper_byte_strobe_t_tx(st_t[1]),
      .upper_byte_strobe_c_tx(st_c[1]), .strobe_oe(strobe_oe),
      .lower_byte_mask(byte_mask[0]), .upper_byte_mask(byte_mask[1]), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_bank(cmd_bank), .row_addr(row_addr), .col_addr(col_addr),
      .auto_precharge(auto_precharge), .burst_chop(burst_chop), .precharge_all(precharge_all),
      .mode_opcode(mode_opcode), .power_state(power_state), .bank_open(bank_open),
      .term_on(term_on), .cmd_buf_en(cmd_buf_en), .ck_buf_en(ck_buf_en),
      .term_buf_en(term_buf_en), .mode_register_one(mode_register_one),
      .wr_overflow(wr_overflow), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .wr_byte_en(wr_byte_en), .wr_fifo_ready(wr_fifo_ready), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .rd_last(rd_last));
   // Shared compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One 8-cycle (200 ns) frame; counts cmd_valid pulses over the whole frame
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
      input logic g, input int v);
      int n;
      n = 0;
      u_ctl.rise(c, b, a, g);
      repeat (3) begin
         @(posedge ref_clk);
         #1;
         if (cmd_valid === 1'b1) n++;
      end
      u_ctl.fall();
      #1;
      if (cmd_valid === 1'b1) n++;
      repeat (3) begin
         @(posedge ref_clk);
         #1;
         if (cmd_valid === 1'b1) n++;
      end
      chk(n, v);
   endtask
   task automatic t_rows();
      issue(spc_pkg::CMD_ACTIVATE, 3'h3, 15'h7ABC, 1'b1, 1);
      chk(row_addr, 15'h7ABC);
      chk({cmd_code, cmd_bank, bank_open}, {spc_pkg::CMD_ACTIVATE, 3'h3, 8'h08});
      issue(4'h8 | spc_pkg::CMD_ACTIVATE, 3'h6, 15'h0001, 1'b1, 0);
      chk(bank_open, 8'h08);
      issue(spc_pkg::CMD_PRECHARGE, 3'h3, 15'h0000, 1'b1, 1);
      chk({precharge_all, bank_open}, 9'h000);
   endtask
   task automatic t_mode();
      issue(spc_pkg::CMD_MODE_SET, 3'h1, 15'h0004, 1'b1, 1);
      chk({mode_opcode, mode_register_one}, {15'h0004, 15'h0004});
      issue(spc_pkg::CMD_MODE_SET, 3'h6, 15'h0040, 1'b1, 1);
      chk(mode_register_one, 15'h0004);
      u_ctl.term(1'b1);
      issue(spc_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b1, 1);
      chk(term_on, 1'b1);
      issue(spc_pkg::CMD_MODE_SET, 3'h1, 15'h0000, 1'b1, 1);
      issue(spc_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b1, 1);
      chk(term_on, 1'b0);
      u_ctl.term(1'b0);
   endtask
   // Ten beats, one fully masked, into eight slots, far side stalled, then drained
   task automatic t_write();
      logic [1:0] m;
      logic [15:0] d;
      logic [15:0] e;
      issue(spc_pkg::CMD_WRITE, 3'h2, 15'h1123, 1'b1, 1);
      chk({col_addr, auto_precharge, burst_chop}, {10'h123, 2'b00});
      for (int i = 0; i < 10; i++) begin
         m = (i == 0) ? 2'b01 : (i == 1) ? 2'b10 : (i == 2) ? 2'b11 : 2'b00;
         u_ctl.beat(16'(16'h1111 * (i + 1)), m);
      end
      repeat (4) @(posedge ref_clk);
      #1;
      chk({wr_overflow, wr_fifo_ready, dq_oe}, 3'b100);
      for (int i = 0; i < 8; i++) begin
         m = (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b11;
         d = {{8{m[1]}}, {8{m[0]}}};
         // The fully masked third beat left no word behind
         e = 16'(16'h1111 * (i + ((i > 1) ? 2 : 1)));
         chk({wr_valid, wr_byte_en, wr_data & d}, {1'b1, m, e & d});
         @(posedge ref_clk);
         wr_ready <= 1'b1;
         @(posedge ref_clk);
         wr_ready <= 1'b0;
         #1;
      end
      chk(wr_valid, 1'b0);
      issue(spc_pkg::CMD_READ, 3'h5, 15'h07FF, 1'b1, 1);
      chk({col_addr, auto_precharge, burst_chop}, {10'h3FF, 2'b11});
   endtask
   // Two back-to-back beats, then the pins are released
   task automatic t_read();
      chk({dq_oe, strobe_oe}, 2'b00);
      @(posedge ref_clk);
      rd_valid <= 1'b1;
      rd_data <= 16'hC3A5;
      prev = st_t;
      @(posedge ref_clk);
      rd_data <= 16'h5A3C;
      rd_last <= 1'b1;
      #1;
      chk({dq_oe, strobe_oe, dq_tx, st_t, st_c}, {2'b11, 16'hC3A5, ~prev, prev});
      prev = st_t;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
      rd_last <= 1'b0;
      #1;
      chk({dq_tx, st_t}, {16'h5A3C, ~prev});
      repeat (4) @(posedge ref_clk);
      #1;
      chk({dq_oe, strobe_oe}, 2'b00);
   endtask
   task automatic t_power();
      issue(spc_pkg::CMD_ACTIVATE, 3'h0, 15'h0001, 1'b1, 1);
      issue(spc_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b0, 0);
      chk(power_state, spc_pkg::SPC_ACT_PDOWN);
      chk({cmd_buf_en, ck_buf_en, term_buf_en, rd_ready}, 4'b0110);
      issue(spc_pkg::CMD_PRECHARGE, 3'h0, 15'h0000, 1'b0, 0);
      issue(spc_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b1, 0);
      chk({power_state, cmd_buf_en, ck_buf_en, term_buf_en, bank_open}, 13'h0701);
      issue(spc_pkg::CMD_PRECHARGE, 3'h0, 15'h0400, 1'b1, 1);
      chk({precharge_all, bank_open}, 9'h100);
      issue(spc_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b0, 0);
      chk(power_state, spc_pkg::SPC_PRE_PDOWN);
      issue(spc_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b1, 0);
      issue(spc_pkg::CMD_REFRESH, 3'h0, 15'h0000, 1'b0, 0);
      chk({power_state, cmd_buf_en, ck_buf_en, term_buf_en}, 5'h18);
      u_ctl.gate(1'b1);
      repeat (6) @(posedge ref_clk);
      #1;
      chk(power_state, spc_pkg::SPC_ACTIVE);
   endtask
   task automatic stop_test();
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #200000;
      mismatches++;
      stop_test();
   end
   initial begin
      nrst = 1'b0;
      wr_ready = 1'b0;
      rd_valid = 1'b0;
      rd_last = 1'b0;
      rd_data = 16'h0000;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      chk({power_state, dq_oe, cmd_code, bank_open}, {2'h0, 1'b0, 4'h7, 8'h00});
      t_rows();
      t_mode();
      t_write();
      t_read();
      t_power();
      stop_test();
   end
endmodule // tb_top
